// file: ppfm_pkg.sv
// Constants, enumerations and carriers for the port pin function multiplexer
package ppfm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_P0_LAT = 8'h00;
  localparam logic [7:0] ADDR_P0_DRV = 8'h04;
  localparam logic [7:0] ADDR_P1_LAT = 8'h08;
  localparam logic [7:0] ADDR_P1_DRV = 8'h0C;
  localparam logic [7:0] ADDR_P2_LAT = 8'h10;
  localparam logic [7:0] ADDR_P2_DRV = 8'h14;
  localparam logic [7:0] ADDR_P3_LAT = 8'h18;
  localparam logic [7:0] ADDR_P3_DRV = 8'h1C;
  localparam logic [7:0] ADDR_ALT    = 8'h20;
  localparam logic [7:0] ADDR_TRIM   = 8'h24;
  localparam logic [7:0] ADDR_PULL   = 8'h28;
  localparam logic [7:0] ADDR_PINS   = 8'h2C;

  // Reset values
  localparam logic [7:0]  LAT_RST  = 8'h00;
  localparam logic [7:0]  DRV_RST  = 8'h00;
  localparam logic [7:0]  TRIM_RST = 8'h00;
  localparam logic [25:0] PULL_RST = 26'h000_0000;
  localparam logic [31:0] ZERO32   = 32'h0000_0000;

  // Field positions
  localparam int TRIM_CLK_OUT_BIT = 6;
  localparam int P0_COMP_TWO_BIT  = 0;
  localparam int P0_COMP_ONE_BIT  = 6;
  localparam int P0_TMR1_BIT      = 7;
  localparam int P1_IN_ONLY_BIT   = 5;
  localparam int P2_MOSI_BIT      = 2;
  localparam int P2_MISO_BIT      = 3;
  localparam int P2_SEL_BIT       = 4;
  localparam int P2_SCK_BIT       = 5;
  localparam int P3_AMP_BIT       = 0;
  localparam int P3_OSC_IN_BIT    = 1;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    PPFM_SRC_RC      = 2'b00,
    PPFM_SRC_WDOG    = 2'b01,
    PPFM_SRC_EXT     = 2'b10,
    PPFM_SRC_CRYSTAL = 2'b11
  } ppfm_clk_src_e;

  typedef struct packed {
    logic tmr1_ovf_en;
    logic spi_master;
    logic spi_en;
    logic comp_one_oe;
    logic comp_two_oe;
  } ppfm_alt_s;

  typedef struct packed {
    logic master_out;
    logic master_in;
    logic serial_if_clock_pin;
  } ppfm_spi_s;
endpackage

// file: ppfm_top.sv
// Port pin function multiplexer with AXI4-Lite register slave
// Operation
// - Under reset every port pin is an undriven input and every pull-up is off.
// - Each pin has its own latch, drive and pull-up bit, independent of its neighbours.
// - In the 20-pin package port P2 is forced to drive and its alternate functions stay off.
// - P2.2 carries master-out: driven as master, an input as slave.
// - P2.3 carries master-in: an input as master, driven as slave.
// - P2.5 carries the serial clock: driven as master, sampled as slave.
// - With the clock-out bit 6 of the trim register set, P3.0 shows the CPU clock divided by two.
// - The divided clock only runs when the CPU clock is not the crystal and the timer does not use it.
// - With a crystal clock source P3.0 is the oscillator amplifier output.
// - P3.1 is a port pin only for RC or watchdog clock with no crystal timer, else the clock input.
// - Keypad input n follows port pin P0.n for n from 0 to 7.
// - P0.7 feeds the timer 1 count input or drives its overflow output.
// - Comparator outputs sit on P0.0 and P0.6, their inputs on P0.1 to P0.4, the reference on P0.5.
// - P1.5 is input-only; the other P1 bits can drive.
`timescale 1ns/1ps
module ppfm_top (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite slave
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             awaddr,
  input  wire logic                    wvalid,
  output logic                         wready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  output logic                         bvalid,
  input  wire logic                    bready,
  output logic [1:0]                   bresp,
  input  wire logic                    arvalid,
  output logic                         arready,
  input  wire logic [31:0]             araddr,
  output logic                         rvalid,
  input  wire logic                    rready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  // Configuration straps, caught while reset is low
  input  wire ppfm_pkg::ppfm_clk_src_e clk_src_cfg,
  input  wire logic                    rtc_on_crystal,
  input  wire logic                    pkg_20pin,
  // Port pins
  input  wire logic [7:0]              p0_in,
  output logic [7:0]                   p0_out,
  output logic [7:0]                   p0_oe_n,
  input  wire logic [7:0]              p1_in,
  output logic [7:0]                   p1_out,
  output logic [7:0]                   p1_oe_n,
  input  wire logic [7:0]              p2_in,
  output logic [7:0]                   p2_out,
  output logic [7:0]                   p2_oe_n,
  input  wire logic [1:0]              p3_in,
  output logic [1:0]                   p3_out,
  output logic [1:0]                   p3_oe_n,
  output logic [25:0]                  pullup_en,
  // Peripheral outputs toward the pins
  input  wire logic                    comparator_one_out,
  input  wire logic                    comparator_two_out,
  input  wire logic                    tmr1_ovf,
  input  wire ppfm_pkg::ppfm_spi_s     spi_from_core,
  input  wire logic                    osc_amp_drive,
  // Pin levels toward the peripherals
  output logic [7:0]                   keypad_input,
  output logic                         comparator_one_pos_a,
  output logic                         comparator_one_pos_b,
  output logic                         comparator_two_pos_a,
  output logic                         comparator_two_pos_b,
  output logic                         comparator_neg_reference,
  output logic                         timer_one_count_pin,
  output ppfm_pkg::ppfm_spi_s          spi_to_core,
  output logic                         spi_sel_n,
  output logic                         osc_input_pin
);
  // Register file and bus state
  logic [7:0] p0_lat_ff, p0_drv_ff, p1_lat_ff, p1_drv_ff, p2_lat_ff, p2_drv_ff;
  logic [7:0] nxt_p0_lat, nxt_p0_drv, nxt_p1_lat, nxt_p1_drv, nxt_p2_lat, nxt_p2_drv;
  logic [1:0] p3_lat_ff, p3_drv_ff, nxt_p3_lat, nxt_p3_drv;
  logic [7:0] trim_ff, nxt_trim;
  logic [25:0] pu_ff, nxt_pu;
  ppfm_pkg::ppfm_alt_s alt_ff, nxt_alt;
  logic        aw_ff, w_ff, nxt_aw, nxt_w;
  logic [7:0]  awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0]  wstrb_ff, nxt_wstrb;
  logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic        nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
  logic [1:0]  bresp_ff, rresp_ff, nxt_bresp, nxt_rresp;
  // Straps and pin state
  ppfm_pkg::ppfm_clk_src_e src_ff, nxt_src;
  logic        rtc_ff, pkg20_ff, nxt_rtc, nxt_pkg20;
  logic [7:0]  p0_in_ff, p1_in_ff, p2_in_ff;
  logic [1:0]  p3_in_ff;
  logic [7:0]  p0_out_ff, p1_out_ff, p2_out_ff, p0_oen_ff, p1_oen_ff, p2_oen_ff;
  logic [7:0]  nxt_p0_out, nxt_p1_out, nxt_p2_out, d0, d1, d2;
  logic [1:0]  p3_out_ff, p3_oen_ff, nxt_p3_out, d3;
  logic        div_ff, nxt_div, clk_ok, clk_on, p31_port;

  always_comb begin
    nxt_aw      = aw_ff;
    nxt_w       = w_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    nxt_p0_lat  = p0_lat_ff;
    nxt_p0_drv  = p0_drv_ff;
    nxt_p1_lat  = p1_lat_ff;
    nxt_p1_drv  = p1_drv_ff;
    nxt_p2_lat  = p2_lat_ff;
    nxt_p2_drv  = p2_drv_ff;
    nxt_p3_lat  = p3_lat_ff;
    nxt_p3_drv  = p3_drv_ff;
    nxt_alt     = alt_ff;
    nxt_trim    = trim_ff;
    nxt_pu      = pu_ff;
    if (awvalid && awready_ff) begin
      nxt_aw     = 1'b1;
      nxt_awaddr = awaddr[7:0];
    end
    if (wvalid && wready_ff) begin
      nxt_w     = 1'b1;
      nxt_wdata = wdata;
      nxt_wstrb = wstrb;
    end
    if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
    // Address and data may arrive in either order; commit once both are held
    if (aw_ff && w_ff && !bvalid_ff) begin
      nxt_aw     = 1'b0;
      nxt_w      = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = ppfm_pkg::RESP_OKAY;
      case (awaddr_ff)
        ppfm_pkg::ADDR_P0_LAT: if (wstrb_ff[0]) nxt_p0_lat = wdata_ff[7:0];
        ppfm_pkg::ADDR_P0_DRV: if (wstrb_ff[0]) nxt_p0_drv = wdata_ff[7:0];
        ppfm_pkg::ADDR_P1_LAT: if (wstrb_ff[0]) nxt_p1_lat = wdata_ff[7:0];
        ppfm_pkg::ADDR_P1_DRV: if (wstrb_ff[0]) nxt_p1_drv = wdata_ff[7:0];
        ppfm_pkg::ADDR_P2_LAT: if (wstrb_ff[0]) nxt_p2_lat = wdata_ff[7:0];
        ppfm_pkg::ADDR_P2_DRV: if (wstrb_ff[0]) nxt_p2_drv = wdata_ff[7:0];
        ppfm_pkg::ADDR_P3_LAT: if (wstrb_ff[0]) nxt_p3_lat = wdata_ff[1:0];
        ppfm_pkg::ADDR_P3_DRV: if (wstrb_ff[0]) nxt_p3_drv = wdata_ff[1:0];
        ppfm_pkg::ADDR_ALT:    if (wstrb_ff[0]) nxt_alt = wdata_ff[4:0];
        ppfm_pkg::ADDR_TRIM:   if (wstrb_ff[0]) nxt_trim = wdata_ff[7:0];
        ppfm_pkg::ADDR_PULL: begin
          if (wstrb_ff[0]) nxt_pu[7:0] = wdata_ff[7:0];
          if (wstrb_ff[1]) nxt_pu[15:8] = wdata_ff[15:8];
          if (wstrb_ff[2]) nxt_pu[23:16] = wdata_ff[23:16];
          if (wstrb_ff[3]) nxt_pu[25:24] = wdata_ff[25:24];
        end
        ppfm_pkg::ADDR_PINS: nxt_bresp = ppfm_pkg::RESP_OKAY;
        default: nxt_bresp = ppfm_pkg::RESP_SLVERR;
      endcase
    end
    if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
    if (arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = ppfm_pkg::RESP_OKAY;
      nxt_rdata  = ppfm_pkg::ZERO32;
      case (araddr[7:0])
        ppfm_pkg::ADDR_P0_LAT: nxt_rdata[7:0] = p0_lat_ff;
        ppfm_pkg::ADDR_P0_DRV: nxt_rdata[7:0] = p0_drv_ff;
        ppfm_pkg::ADDR_P1_LAT: nxt_rdata[7:0] = p1_lat_ff;
        ppfm_pkg::ADDR_P1_DRV: nxt_rdata[7:0] = p1_drv_ff;
        ppfm_pkg::ADDR_P2_LAT: nxt_rdata[7:0] = p2_lat_ff;
        ppfm_pkg::ADDR_P2_DRV: nxt_rdata[7:0] = p2_drv_ff;
        ppfm_pkg::ADDR_P3_LAT: nxt_rdata[1:0] = p3_lat_ff;
        ppfm_pkg::ADDR_P3_DRV: nxt_rdata[1:0] = p3_drv_ff;
        ppfm_pkg::ADDR_ALT:    nxt_rdata[4:0] = alt_ff;
        ppfm_pkg::ADDR_TRIM:   nxt_rdata[7:0] = trim_ff;
        ppfm_pkg::ADDR_PULL:   nxt_rdata[25:0] = pu_ff;
        ppfm_pkg::ADDR_PINS:   nxt_rdata = {rtc_ff, pkg20_ff, src_ff, 2'b00,
                                            p1_in_ff, p3_in_ff, p2_in_ff, p0_in_ff};
        default:               nxt_rresp = ppfm_pkg::RESP_SLVERR;
      endcase
    end
    nxt_awready = !nxt_aw && !nxt_bvalid;
    nxt_wready  = !nxt_w && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff      <= 1'b0;
      w_ff       <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= ppfm_pkg::ZERO32;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= ppfm_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= ppfm_pkg::ZERO32;
      rresp_ff   <= ppfm_pkg::RESP_OKAY;
      p0_lat_ff  <= ppfm_pkg::LAT_RST;
      p0_drv_ff  <= ppfm_pkg::DRV_RST;
      p1_lat_ff  <= ppfm_pkg::LAT_RST;
      p1_drv_ff  <= ppfm_pkg::DRV_RST;
      p2_lat_ff  <= ppfm_pkg::LAT_RST;
      p2_drv_ff  <= ppfm_pkg::DRV_RST;
      p3_lat_ff  <= ppfm_pkg::LAT_RST[1:0];
      p3_drv_ff  <= ppfm_pkg::DRV_RST[1:0];
      alt_ff     <= '0;
      trim_ff    <= ppfm_pkg::TRIM_RST;
      pu_ff      <= ppfm_pkg::PULL_RST;
    end else begin
      aw_ff      <= nxt_aw;
      w_ff       <= nxt_w;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      p0_lat_ff  <= nxt_p0_lat;
      p0_drv_ff  <= nxt_p0_drv;
      p1_lat_ff  <= nxt_p1_lat;
      p1_drv_ff  <= nxt_p1_drv;
      p2_lat_ff  <= nxt_p2_lat;
      p2_drv_ff  <= nxt_p2_drv;
      p3_lat_ff  <= nxt_p3_lat;
      p3_drv_ff  <= nxt_p3_drv;
      alt_ff     <= nxt_alt;
      trim_ff    <= nxt_trim;
      pu_ff      <= nxt_pu;
    end
  end

  // Pin steering
  always_comb begin
    // Straps follow their pins only while reset holds, then freeze
    nxt_src   = aresetn ? src_ff : clk_src_cfg;
    nxt_rtc   = aresetn ? rtc_ff : rtc_on_crystal;
    nxt_pkg20 = aresetn ? pkg20_ff : pkg_20pin;
    clk_ok    = (src_ff != ppfm_pkg::PPFM_SRC_CRYSTAL) && !rtc_ff;
    clk_on    = trim_ff[ppfm_pkg::TRIM_CLK_OUT_BIT] && clk_ok;
    nxt_div   = clk_on ? !div_ff : 1'b0;
    p31_port  = ((src_ff == ppfm_pkg::PPFM_SRC_RC) || (src_ff == ppfm_pkg::PPFM_SRC_WDOG))
                && !rtc_ff;
    nxt_p0_out = p0_lat_ff;
    d0         = p0_drv_ff;
    if (alt_ff.comp_two_oe) begin
      nxt_p0_out[ppfm_pkg::P0_COMP_TWO_BIT] = comparator_two_out;
      d0[ppfm_pkg::P0_COMP_TWO_BIT]         = 1'b1;
    end
    if (alt_ff.comp_one_oe) begin
      nxt_p0_out[ppfm_pkg::P0_COMP_ONE_BIT] = comparator_one_out;
      d0[ppfm_pkg::P0_COMP_ONE_BIT]         = 1'b1;
    end
    if (alt_ff.tmr1_ovf_en) begin
      nxt_p0_out[ppfm_pkg::P0_TMR1_BIT] = tmr1_ovf;
      d0[ppfm_pkg::P0_TMR1_BIT]         = 1'b1;
    end
    nxt_p1_out = p1_lat_ff;
    d1         = p1_drv_ff;
    d1[ppfm_pkg::P1_IN_ONLY_BIT] = 1'b0;
    nxt_p2_out = p2_lat_ff;
    d2         = p2_drv_ff;
    if (pkg20_ff) begin
      // Unbonded port parks driving low so its inputs never float
      nxt_p2_out = ppfm_pkg::LAT_RST;
      d2         = 8'hFF;
    end else if (alt_ff.spi_en) begin
      nxt_p2_out[ppfm_pkg::P2_MOSI_BIT] = spi_from_core.master_out;
      d2[ppfm_pkg::P2_MOSI_BIT]         = alt_ff.spi_master;
      nxt_p2_out[ppfm_pkg::P2_MISO_BIT] = spi_from_core.master_in;
      d2[ppfm_pkg::P2_MISO_BIT]         = !alt_ff.spi_master;
      d2[ppfm_pkg::P2_SEL_BIT]          = 1'b0;
      nxt_p2_out[ppfm_pkg::P2_SCK_BIT]  = spi_from_core.serial_if_clock_pin;
      d2[ppfm_pkg::P2_SCK_BIT]          = alt_ff.spi_master;
    end
    nxt_p3_out = p3_lat_ff;
    d3         = p3_drv_ff;
    if (src_ff == ppfm_pkg::PPFM_SRC_CRYSTAL) begin
      nxt_p3_out[ppfm_pkg::P3_AMP_BIT] = osc_amp_drive;
      d3[ppfm_pkg::P3_AMP_BIT]         = 1'b1;
    end else if (clk_on) begin
      nxt_p3_out[ppfm_pkg::P3_AMP_BIT] = div_ff;
      d3[ppfm_pkg::P3_AMP_BIT]         = 1'b1;
    end
    if (!p31_port) begin
      d3[ppfm_pkg::P3_OSC_IN_BIT] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    src_ff   <= nxt_src;
    rtc_ff   <= nxt_rtc;
    pkg20_ff <= nxt_pkg20;
    p0_in_ff <= p0_in;
    p1_in_ff <= p1_in;
    p2_in_ff <= p2_in;
    p3_in_ff <= p3_in;
    if (!aresetn) begin
      div_ff    <= 1'b0;
      p0_out_ff <= ppfm_pkg::LAT_RST;
      p1_out_ff <= ppfm_pkg::LAT_RST;
      p2_out_ff <= ppfm_pkg::LAT_RST;
      p3_out_ff <= ppfm_pkg::LAT_RST[1:0];
      p0_oen_ff <= 8'hFF;
      p1_oen_ff <= 8'hFF;
      p2_oen_ff <= 8'hFF;
      p3_oen_ff <= 2'b11;
    end else begin
      div_ff    <= nxt_div;
      p0_out_ff <= nxt_p0_out;
      p1_out_ff <= nxt_p1_out;
      p2_out_ff <= nxt_p2_out;
      p3_out_ff <= nxt_p3_out;
      p0_oen_ff <= ~d0;
      p1_oen_ff <= ~d1;
      p2_oen_ff <= ~d2;
      p3_oen_ff <= ~d3;
    end
  end

  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
  assign p0_out  = p0_out_ff;
  assign p0_oe_n = p0_oen_ff;
  assign p1_out  = p1_out_ff;
  assign p1_oe_n = p1_oen_ff;
  assign p2_out  = p2_out_ff;
  assign p2_oe_n = p2_oen_ff;
  assign p3_out  = p3_out_ff;
  assign p3_oe_n = p3_oen_ff;
  assign pullup_en = pu_ff;
  assign keypad_input = p0_in_ff;
  assign comparator_two_pos_b = p0_in_ff[1];
  assign comparator_two_pos_a = p0_in_ff[2];
  assign comparator_one_pos_b = p0_in_ff[3];
  assign comparator_one_pos_a = p0_in_ff[4];
  assign comparator_neg_reference = p0_in_ff[5];
  assign timer_one_count_pin = p0_in_ff[ppfm_pkg::P0_TMR1_BIT];
  assign spi_to_core.master_out = p2_in_ff[ppfm_pkg::P2_MOSI_BIT];
  assign spi_to_core.master_in = p2_in_ff[ppfm_pkg::P2_MISO_BIT];
  assign spi_to_core.serial_if_clock_pin = p2_in_ff[ppfm_pkg::P2_SCK_BIT];
  assign spi_sel_n = p2_in_ff[ppfm_pkg::P2_SEL_BIT];
  assign osc_input_pin = p3_in_ff[ppfm_pkg::P3_OSC_IN_BIT];

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_pins_input_a: assert property ($past(!aresetn) |-> (&p0_oe_n) && (&p2_oe_n)
    && (&p3_oe_n) && (pullup_en == ppfm_pkg::PULL_RST)) else $error("pins not released");
  p1_in_only_a: assert property (p1_oe_n[5]) else $error("P1.5 driven");
  small_pkg_a: assert property ($past(aresetn) && pkg20_ff |-> p2_oe_n == 8'h00)
    else $error("P2 not forced out");
  spi_master_a: assert property (alt_ff.spi_en && alt_ff.spi_master && !pkg20_ff
    && $stable(alt_ff) |=> !p2_oe_n[2] && !p2_oe_n[5] && p2_oe_n[3]
    && p2_out[2] == $past(spi_from_core.master_out)) else $error("spi master pins");
  spi_slave_a: assert property (alt_ff.spi_en && !alt_ff.spi_master && !pkg20_ff
    |=> !p2_oe_n[3] && p2_oe_n[2] && p2_oe_n[5] && p2_oe_n[4]) else $error("spi slave pins");
  clock_div_a: assert property (clk_on && $past(clk_on) && $past(aresetn, 2)
    |=> !p3_oe_n[0] && p3_out[0] != $past(p3_out[0])) else $error("clock out not toggling");
  crystal_amp_a: assert property (src_ff == ppfm_pkg::PPFM_SRC_CRYSTAL
    |=> !p3_oe_n[0] && p3_out[0] == $past(osc_amp_drive)) else $error("amp pin wrong");
  osc_in_a: assert property (!p31_port |=> p3_oe_n[1]) else $error("P3.1 driven");
  keypad_map_a: assert property ($past(aresetn) |-> keypad_input == $past(p0_in))
    else $error("keypad map");
  comp_drive_a: assert property (alt_ff.comp_one_oe |=> !p0_oe_n[6]
    && p0_out[6] == $past(comparator_one_out)) else $error("comparator out");
endmodule

// file: ppfm_board.sv
// Board model: external circuits that drive the released port pins
`timescale 1ns/1ps
module ppfm_board #(
  parameter int W = 8
) (
  // Device side
  input  wire logic [W-1:0] dev_out,
  input  wire logic [W-1:0] dev_oe_n,
  // External driver level
  input  wire logic [W-1:0] ext_lvl,
  // Resolved pin level
  output logic      [W-1:0] pin
);
  // Device wins where it drives; a keypad or chip drives the rest, so no pin floats
  assign pin = (dev_out & ~dev_oe_n) | (ext_lvl & dev_oe_n);
endmodule

// file: tb_top.sv
// Self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps
module tb_top;
  logic                    aclk = 1'h0;
  logic                    aresetn = 1'h0;
  logic                    awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic                    arvalid = 1'h0, rready = 1'h0;
  logic [31:0]             awaddr = 32'h0000_0000, wdata = 32'h0000_0000;
  logic [31:0]             araddr = 32'h0000_0000, rdata, rd;
  logic [3:0]              wstrb = 4'hf;
  logic                    awready, wready, bvalid, arready, rvalid;
  logic [1:0]              bresp, rresp, rs;
  ppfm_pkg::ppfm_clk_src_e clk_src_cfg = ppfm_pkg::PPFM_SRC_RC;
  logic                    rtc_on_crystal = 1'h0, pkg_20pin = 1'h0;
  logic [7:0]              p0_in, p0_out, p0_oe_n, p1_in, p1_out, p1_oe_n;
  logic [7:0]              p2_in, p2_out, p2_oe_n, keypad_input;
  logic [1:0]              p3_in, p3_out, p3_oe_n;
  logic [25:0]             pullup_en;
  logic                    comparator_one_out = 1'h0, comparator_two_out = 1'h0;
  logic                    tmr1_ovf = 1'h0, osc_amp_drive = 1'h0;
  ppfm_pkg::ppfm_spi_s     spi_from_core = 3'h0, spi_to_core;
  logic                    comparator_one_pos_a, comparator_one_pos_b, comparator_two_pos_a;
  logic                    comparator_two_pos_b, comparator_neg_reference;
  logic                    timer_one_count_pin, spi_sel_n, osc_input_pin, a0, ck, gp;
  logic [7:0]              ext0 = 8'h00, ext1 = 8'h00, ext2 = 8'h00, pat;
  logic [1:0]              ext3 = 2'h0;
  int                      n_errors = 0, checks = 0, cycles = 0;

  ppfm_board #(.W(8)) brd0 (.dev_out(p0_out), .dev_oe_n(p0_oe_n), .ext_lvl(ext0), .pin(p0_in));
  ppfm_board #(.W(8)) brd1 (.dev_out(p1_out), .dev_oe_n(p1_oe_n), .ext_lvl(ext1), .pin(p1_in));
  ppfm_board #(.W(8)) brd2 (.dev_out(p2_out), .dev_oe_n(p2_oe_n), .ext_lvl(ext2), .pin(p2_in));
  ppfm_board #(.W(2)) brd3 (.dev_out(p3_out), .dev_oe_n(p3_oe_n), .ext_lvl(ext3), .pin(p3_in));

  ppfm_top uut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .clk_src_cfg(clk_src_cfg), .rtc_on_crystal(rtc_on_crystal), .pkg_20pin(pkg_20pin),
    .p0_in(p0_in), .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p1_in(p1_in), .p1_out(p1_out),
    .p1_oe_n(p1_oe_n), .p2_in(p2_in), .p2_out(p2_out), .p2_oe_n(p2_oe_n), .p3_in(p3_in),
    .p3_out(p3_out), .p3_oe_n(p3_oe_n), .pullup_en(pullup_en),
    .comparator_one_out(comparator_one_out), .comparator_two_out(comparator_two_out),
    .tmr1_ovf(tmr1_ovf), .spi_from_core(spi_from_core), .osc_amp_drive(osc_amp_drive),
    .keypad_input(keypad_input), .comparator_one_pos_a(comparator_one_pos_a),
    .comparator_one_pos_b(comparator_one_pos_b), .comparator_two_pos_a(comparator_two_pos_a),
    .comparator_two_pos_b(comparator_two_pos_b),
    .comparator_neg_reference(comparator_neg_reference),
    .timer_one_count_pin(timer_one_count_pin), .spi_to_core(spi_to_core),
    .spi_sel_n(spi_sel_n), .osc_input_pin(osc_input_pin)
  );

  initial begin
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Counts: checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Readiness sampled at the falling edge, so the handshake edge is known without races
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic at, wt, ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge aclk);
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      at = awvalid && awready;
      wt = wvalid && wready;
      @(posedge aclk);
      if (at) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (wt) begin
        wd = 1'h1;
        wvalid <= 1'h0;
      end
    end
    at = 1'h0;
    while (!at) begin
      @(negedge aclk);
      at = bvalid;
      rs = bresp;
      @(posedge aclk);
    end
    bready <= 1'h0;
    chk(rs, er);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t;
    t = 1'h0;
    @(posedge aclk);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!t) begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    arvalid <= 1'h0;
    t = 1'h0;
    while (!t) begin
      @(negedge aclk);
      t = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
    end
    rready <= 1'h0;
    chk(rd, ed);
    chk(rs, er);
  endtask

  task automatic do_reset(input logic [1:0] src, input logic rtc, input logic p20);
    @(posedge aclk);
    aresetn <= 1'h0;
    clk_src_cfg <= ppfm_pkg::ppfm_clk_src_e'(src);
    rtc_on_crystal <= rtc;
    pkg_20pin <= p20;
    settle(2);
    chk({p0_oe_n, p1_oe_n, p2_oe_n, p3_oe_n}, 26'h3ff_ffff);
    chk(pullup_en, 26'h000_0000);
    @(posedge aclk);
    aresetn <= 1'h1;
    settle(2);
  endtask

  // Generous ceiling: the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    do_reset(2'h0, 1'h0, 1'h0);
    for (int a = 0; a < 11; a++) begin
      rd_chk(8'(4 * a), 32'h0000_0000, ppfm_pkg::RESP_OKAY);
    end
    rd_chk(8'h30, 32'h0000_0000, ppfm_pkg::RESP_SLVERR);
    wr(8'h30, 32'hffff_ffff, ppfm_pkg::RESP_SLVERR);
    // Trim left out: its clock-out bit would toggle P3.0 under the pin read
    for (int a = 0; a < 11; a++) begin
      if (a != 9) begin
        wr(8'(4 * a), 32'hffff_ffff, ppfm_pkg::RESP_OKAY);
        rd_chk(8'(4 * a), a < 6 ? 32'hff : a < 8 ? 32'h3 : a == 8 ? 32'h1f : 32'h3ff_ffff,
               ppfm_pkg::RESP_OKAY);
      end
    end
    wr(ppfm_pkg::ADDR_PINS, 32'hffff_ffff, ppfm_pkg::RESP_OKAY);
    settle(2);
    rd_chk(ppfm_pkg::ADDR_PINS, {6'h00, 8'hdf, 2'h3, 8'hc3, 8'h3e}, ppfm_pkg::RESP_OKAY);
    do_reset(2'h0, 1'h0, 1'h0);
    $display("test registers done");
    wr(ppfm_pkg::ADDR_P1_DRV, 8'h6c, ppfm_pkg::RESP_OKAY);
    wr(ppfm_pkg::ADDR_P1_LAT, 8'h5a, ppfm_pkg::RESP_OKAY);
    wr(ppfm_pkg::ADDR_PULL, 32'h0155_5555, ppfm_pkg::RESP_OKAY);
    settle(2);
    chk(p1_oe_n, 8'hb3);
    chk(p1_out & 8'h4c, 8'h48);
    chk(pullup_en, 26'h155_5555);
    for (int i = 0; i < 2; i++) begin
      pat = i == 0 ? 8'h5a : 8'ha5;
      @(posedge aclk);
      ext0 <= pat;
      settle(3);
      chk(keypad_input, pat);
      chk({comparator_two_pos_b, comparator_two_pos_a, comparator_one_pos_b,
           comparator_one_pos_a, comparator_neg_reference, timer_one_count_pin},
          {pat[1], pat[2], pat[3], pat[4], pat[5], pat[7]});
    end
    wr(ppfm_pkg::ADDR_P0_DRV, 8'hc1, ppfm_pkg::RESP_OKAY);
    wr(ppfm_pkg::ADDR_P0_LAT, 8'h00, ppfm_pkg::RESP_OKAY);
    wr(ppfm_pkg::ADDR_ALT, 8'h13, ppfm_pkg::RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      comparator_one_out <= i[0];
      comparator_two_out <= !i[0];
      tmr1_ovf <= i[0];
      settle(2);
      chk(p0_out & 8'hc1, {i[0], i[0], 5'h00, !i[0]});
      chk(p0_oe_n & 8'hc1, 8'h00);
    end
    wr(ppfm_pkg::ADDR_ALT, 8'h00, ppfm_pkg::RESP_OKAY);
    settle(2);
    chk(p0_out & 8'hc1, 8'h00);
    $display("test port zero done");
    wr(ppfm_pkg::ADDR_P2_DRV, 8'hff, ppfm_pkg::RESP_OKAY);
    wr(ppfm_pkg::ADDR_P2_LAT, 8'hff, ppfm_pkg::RESP_OKAY);
    wr(ppfm_pkg::ADDR_ALT, 8'h0c, ppfm_pkg::RESP_OKAY);
    @(posedge aclk);
    ext2 <= 8'h18;
    settle(2);
    chk(p2_oe_n & 8'h3c, 8'h18);
    chk({p2_out[2], p2_out[5]}, 2'h0);
    chk({spi_to_core.master_in, spi_sel_n}, 2'h3);
    wr(ppfm_pkg::ADDR_ALT, 8'h04, ppfm_pkg::RESP_OKAY);
    @(posedge aclk);
    ext2 <= 8'h2c;
    settle(2);
    chk(p2_oe_n & 8'h3c, 8'h34);
    chk(p2_out[3], 1'h0);
    chk({spi_to_core.master_out, spi_to_core.serial_if_clock_pin, spi_sel_n}, 3'h6);
    $display("test serial pins done");
    for (int k = 0; k < 8; k++) begin
      do_reset(k[1:0], k[2], 1'h0);
      wr(ppfm_pkg::ADDR_P3_DRV, 8'h03, ppfm_pkg::RESP_OKAY);
      wr(ppfm_pkg::ADDR_TRIM, 8'h40, ppfm_pkg::RESP_OKAY);
      rd_chk(ppfm_pkg::ADDR_TRIM, 32'h0000_0040, ppfm_pkg::RESP_OKAY);
      @(posedge aclk);
      osc_amp_drive <= 1'h1;
      ext3 <= 2'h2;
      settle(2);
      a0 = p3_out[0];
      ck = k[1:0] != 2'h3 && !k[2];
      gp = k[1:0] < 2'h2 && !k[2];
      @(negedge aclk);
      if (k[1:0] == 2'h3) begin
        chk(p3_out[0], 1'h1);
      end else begin
        chk(p3_out[0], ck ? !a0 : 1'h0);
      end
      chk(p3_oe_n[0], 1'h0);
      if (gp) begin
        chk(p3_oe_n[1], 1'h0);
      end else begin
        chk({p3_oe_n[1], osc_input_pin}, 2'h3);
      end
    end
    $display("test clock pins done");
    do_reset(2'h0, 1'h0, 1'h1);
    wr(ppfm_pkg::ADDR_P2_DRV, 8'h00, ppfm_pkg::RESP_OKAY);
    wr(ppfm_pkg::ADDR_P2_LAT, 8'hff, ppfm_pkg::RESP_OKAY);
    settle(2);
    chk({p2_oe_n, p2_out}, 16'h0000);
    $display("test small package done");
    conclude();
  end
endmodule
